//--- dv/csec_host_model.sv
// Management host model issuing register reads and writes
`default_nettype none
`include "csec_cfg.svh"

module csec_host_model
  import csec_pkg::*;
(
  input wire logic sys_clk,
  output logic regRdStb,
  output logic regWrStb,
  output logic [`CSEC_ADDR_W-1:0] regAddr,
  output logic [`CSEC_DATA_W-1:0] regWrData,
  input wire logic [`CSEC_DATA_W-1:0] regRdData,
  input wire logic regRdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus values carry no meaning
  initial
  begin
    regRdStb = 1'b0;
    regWrStb = 1'b0;
    regAddr = 5'h15;
    regWrData = 16'hA5A5;
  end
  ////////////////////////////////////////////////////////////
  // Read: strobe taken at one edge, answer awaited for a bounded time
  task automatic rd(input logic [`CSEC_ADDR_W-1:0] a, output csec_word_type d);
    int n;
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    regAddr <= ~a;
    n = 0;
    d = 'x;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (regRdValid !== 1'b1 && n < 4);
    if (regRdValid === 1'b1)
      d = regRdData;
  endtask
  // Write: no answer, taken at the edge after the strobe rises
  task automatic wr(input logic [`CSEC_ADDR_W-1:0] a, input csec_word_type d);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
endmodule // csec_host_model

`default_nettype wire

//--- dv/csec_status_regs_assertions.sv
// Assertion checker for the channel status and error counter register set
`default_nettype none
`include "csec_cfg.svh"

module csec_status_regs_chk
  import csec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic regRdStb,
  input wire logic regWrStb,
  input wire logic [`CSEC_ADDR_W-1:0] regAddr,
  input wire logic [`CSEC_DATA_W-1:0] regWrData,
  input wire logic [`CSEC_DATA_W-1:0] regRdData,
  input wire logic regRdValid,
  input wire logic fast_pattern_aligned,
  input wire logic training_failed_flag,
  input wire logic fast_signal_lost,
  input wire logic fast_sync_achieved,
  input wire logic fast_bad_codeword,
  input wire logic decoderEnable,
  input wire logic random_jitter_pattern,
  input wire logic marker_search_done,
  input wire logic rx_bitwise_interleave,
  input wire logic training_frame_found,
  input wire logic fastPatternErr,
  input wire logic fastPrbsErr,
  input wire logic datapathReset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Decoded host accesses and fast error events
  wire logic rdSt = clkEn && regRdStb && regAddr == `CSEC_ADDR_STATUS;
  wire logic rdFast = clkEn && regRdStb && regAddr == `CSEC_ADDR_FAST_ERR;
  wire logic fastEvt = fast_bad_codeword || fastPatternErr || fastPrbsErr;
  wire logic dpWr = clkEn && regWrStb && regAddr == `CSEC_ADDR_RESET_CTRL && regWrData[`CSEC_RC_DATAPATH];
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  // Condition seen, one idle cycle, then a status read
  sequence seenThenRd(e);
    e && clkEn ##1 (clkEn && !rdSt) ##1 rdSt;
  endsequence
  // Two fast counter reads with no error before the second
  sequence quietReads;
    rdFast && !fastEvt ##1 (clkEn && !fastEvt)[*2] ##1 rdFast;
  endsequence
  ////////////////////////////////////////////////////////////
  pat_live_a: assert property (rdSt |=> regRdData[15] == $past(fast_pattern_aligned))
    else $error("pattern status bit not live");
  frame_live_a: assert property (rdSt |=> regRdData[3] == $past(training_frame_found))
    else $error("frame lock bit not live");
  fail_latch_a: assert property (seenThenRd(training_failed_flag) |=> regRdData[14])
    else $error("training failure not held");
  los_latch_a: assert property (seenThenRd(fast_signal_lost) |=> regRdData[13])
    else $error("loss of signal not held");
  sync_low_a: assert property (seenThenRd(!fast_sync_achieved) |=> !regRdData[10])
    else $error("sync loss not held low");
  bad_code_a: assert property (seenThenRd(fast_bad_codeword && (decoderEnable || random_jitter_pattern))
    |=> regRdData[8])
    else $error("bad code word not held");
  marker_latch_a: assert property (seenThenRd(marker_search_done && rx_bitwise_interleave) |=> regRdData[4])
    else $error("marker done not held");
  count_clear_a: assert property (quietReads |=> regRdData == `CSEC_ERR_CLEARED)
    else $error("fast counter not cleared by read");
  dp_pulse_a: assert property (dpWr |=> datapathReset ##1 (!datapathReset || $past(dpWr) || !$past(clkEn)))
    else $error("datapath reset not a single pulse");
  rd_answer_a: assert property (clkEn |=> regRdValid == $past(regRdStb))
    else $error("read answer not one cycle after the strobe");
endmodule // csec_status_regs_chk

bind csec_status_regs csec_status_regs_chk csec_status_regs_chk_inst (
  .sys_clk, .srst, .clkEn, .regRdStb, .regWrStb, .regAddr, .regWrData, .regRdData, .regRdValid,
  .fast_pattern_aligned, .training_failed_flag, .fast_signal_lost, .fast_sync_achieved,
  .fast_bad_codeword, .decoderEnable, .random_jitter_pattern, .marker_search_done,
  .rx_bitwise_interleave, .training_frame_found, .fastPatternErr, .fastPrbsErr, .datapathReset
);

`default_nettype wire

//--- dv/csec_status_regs_tb_top.sv
// Testbench top for the channel status and error counter register set
`default_nettype none
`include "csec_cfg.svh"

module csec_status_regs_tb_top
  import csec_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, srst = 1'b1, clkEn = 1'b1;
  logic [2:0] lane_select_field = 3'h0;
  logic fastTestMode = 1'b0, laneTestMode = 1'b0, decoderEnable = 1'b0, random_jitter_pattern = 1'b0;
  logic rx_bitwise_interleave = 1'b0, pattern_check_pin = 1'b0, fastPatternErr = 1'b0, fastPrbsErr = 1'b0;
  logic [7:0] lv = 8'h00;
  logic [3:0] ev = 4'h0, laneBadCodeword = 4'h0, lanePatternErr = 4'h0, laneFifoReset;
  logic regRdStb, regWrStb, regRdValid, restartTraining, datapathReset;
  logic [4:0] regAddr;
  csec_word_type regWrData, regRdData, rd;
  int err_count = 0, num_checks = 0;

  always #5 sys_clk = ~sys_clk;

  // Levels in lv, one-cycle events in ev
  csec_status_regs csec_status_regs_inst (
    .sys_clk, .srst, .clkEn, .regRdStb, .regWrStb, .regAddr, .regWrData, .regRdData, .regRdValid,
    .lane_select_field, .fastTestMode, .laneTestMode, .decoderEnable, .random_jitter_pattern,
    .rx_bitwise_interleave, .pattern_check_pin, .fast_pattern_aligned(lv[7]), .training_frame_found(lv[6]),
    .receiver_trained(lv[5]), .autozero_complete(lv[4]), .gain_loop_locked(lv[3]), .fast_sync_achieved(lv[2]),
    .slow_pll_locked(lv[1]), .fast_pll_locked(lv[0]), .training_failed_flag(ev[3]), .fast_signal_lost(ev[2]),
    .fast_bad_codeword(ev[1]), .marker_search_done(ev[0]), .fastPatternErr, .fastPrbsErr,
    .laneBadCodeword, .lanePatternErr, .laneFifoReset, .restartTraining, .datapathReset);
  csec_host_model csec_host_model_inst (.sys_clk, .regRdStb, .regWrStb, .regAddr, .regWrData,
    .regRdData, .regRdValid);
  ////////////////////////////////////////////////////////////
  task automatic chk(input csec_word_type got, input csec_word_type exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input csec_word_type exp);
    csec_word_type d;
    csec_host_model_inst.rd(a, d);
    chk(d, exp);
  endtask
  // Events high for exactly one cycle, then quiet
  task automatic fire(input logic [3:0] e, input logic [1:0] f, input logic [3:0] lb, input logic [3:0] lp);
    @(posedge sys_clk);
    ev <= e;
    {fastPatternErr, fastPrbsErr} <= f;
    laneBadCodeword <= lb;
    lanePatternErr <= lp;
    @(posedge sys_clk);
    ev <= 4'h0;
    {fastPatternErr, fastPrbsErr} <= 2'b00;
    laneBadCodeword <= 4'h0;
    lanePatternErr <= 4'h0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    #20000;
    err_count++;
    $display("mismatch at %0t: run timed out", $time);
    close_out();
  end
  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rdc(5'h0F, 16'h0000);
    rdc(5'h10, 16'hFFFD);
    rdc(5'h10, 16'h0000);
    rdc(5'h12, 16'h0000);
    $display("test reset done");
    // Latched bits hold after their cause is gone; latched-low held low from reset
    lv <= 8'hFF;
    decoderEnable <= 1'b1;
    rx_bitwise_interleave <= 1'b1;
    fire(4'hF, 2'b00, 4'h0, 4'h0);
    rdc(5'h0F, 16'hE11C);
    rdc(5'h0F, 16'h9C0F);
    lv <= 8'hFA;
    @(posedge sys_clk);
    lv <= 8'hFF;
    rdc(5'h0F, 16'h980E);
    decoderEnable <= 1'b0;
    rx_bitwise_interleave <= 1'b0;
    fire(4'h3, 2'b00, 4'h0, 4'h0);
    rdc(5'h0F, 16'h9C0F);
    random_jitter_pattern <= 1'b1;
    lv <= 8'h00;
    fire(4'h2, 2'b00, 4'h0, 4'h0);
    rdc(5'h0F, 16'h0100);
    $display("test status done");
    // Fast counter sources: functional, test mode, then the pin
    csec_host_model_inst.rd(5'h10, rd);
    repeat (3) fire(4'h2, 2'b11, 4'h0, 4'h0);
    rdc(5'h10, 16'h0003);
    fastTestMode <= 1'b1;
    repeat (2) fire(4'h2, 2'b10, 4'h0, 4'h0);
    fire(4'h2, 2'b01, 4'h0, 4'h0);
    rdc(5'h10, 16'h0002);
    pattern_check_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    repeat (3) fire(4'h2, 2'b01, 4'h0, 4'h0);
    fire(4'h2, 2'b10, 4'h0, 4'h0);
    rdc(5'h10, 16'h0003);
    pattern_check_pin <= 1'b0;
    fastTestMode <= 1'b0;
    $display("test fast counter done");
    // Lane counters: each lane gets a different count
    for (int i = 0; i < 4; i++)
    begin
      lane_select_field <= 3'(i);
      rdc(5'h11, 16'hFFFD);
    end
    fire(4'h0, 2'b00, 4'hF, 4'hF);
    fire(4'h0, 2'b00, 4'hE, 4'h0);
    fire(4'h0, 2'b00, 4'hC, 4'h0);
    fire(4'h0, 2'b00, 4'h8, 4'h0);
    laneTestMode <= 1'b1;
    fire(4'h0, 2'b00, 4'hF, 4'hF);
    fire(4'h0, 2'b00, 4'h0, 4'hF);
    for (int i = 0; i < 5; i++)
    begin
      lane_select_field <= 3'(i);
      rdc(5'h11, (i < 4) ? 16'(i + 3) : 16'h0000);
    end
    lane_select_field <= 3'h0;
    rdc(5'h11, 16'h0000);
    laneTestMode <= 1'b0;
    $display("test lane counter done");
    // Clock enable low: error events and a reset control write are ignored
    clkEn <= 1'b0;
    fire(4'h2, 2'b00, 4'h1, 4'h0);
    csec_host_model_inst.wr(5'h0E, 16'h0008);
    @(posedge sys_clk);
    chk({10'h000, laneFifoReset, restartTraining, datapathReset}, 16'h0000);
    clkEn <= 1'b1;
    rdc(5'h10, 16'h0000);
    rdc(5'h11, 16'h0000);
    $display("test clock enable done");
    // Self-clearing reset controls
    csec_host_model_inst.wr(5'h0E, 16'h0F18);
    @(posedge sys_clk);
    chk({10'h000, laneFifoReset, restartTraining, datapathReset}, 16'h003F);
    @(posedge sys_clk);
    chk({10'h000, laneFifoReset, restartTraining, datapathReset}, 16'h0000);
    $display("test reset control done");
    close_out();
  end
endmodule // csec_status_regs_tb_top

`default_nettype wire

//--- hw/csec_err_counters.sv
// Bank of saturating clear-on-read error counters
`default_nettype none
`include "csec_cfg.svh"

module csec_err_counters
  import csec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  csec_cnt_if.bank cnt
);

  csec_cnt_state_type cur_ff;
  csec_cnt_state_type nxt_cur;

  // Saturating step: a wrapped count would hide a burst of errors
  function automatic csec_word_type bump(input csec_word_type v);
    bump = (v == `CSEC_ERR_MAX) ? v : csec_word_type'(v + 1'b1);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Next counts: an error in the read cycle survives the clear
  always_comb
  begin
    nxt_cur = cur_ff;
    for (int i = 0; i < `CSEC_NUM_CNT; i++)
    begin
      if (cnt.clr[i])
      begin
        nxt_cur.count[i] = cnt.incr[i] ? bump(`CSEC_ERR_CLEARED) : `CSEC_ERR_CLEARED;
      end
      else if (cnt.incr[i])
      begin
        nxt_cur.count[i] = bump(cur_ff.count[i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < `CSEC_NUM_CNT; i++)
      begin
        cur_ff.count[i] <= `CSEC_ERR_RESET;
      end
    end
    else if (clkEn)
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign cnt.count = cur_ff.count;

endmodule : csec_err_counters
`default_nettype wire

//--- hw/csec_status_regs.sv
// Channel status register and error counter registers of one channel
// Overview of operation
// - Bit 15 is live: one when pattern aligned and correct, else zero.
// - Bit 14 latches high on a link training failure.
// - Bit 13 latches high on fast receive loss of signal.
// - Bit 12 reports auto-zero calibration complete, latched low.
// - Bit 11 reports gain control loop lock, latched low.
// - Bit 10 reports fast channel synchronization, latched low.
// - Bit 8 latches high on invalid code word, gated by decoder or pattern check.
// - Bit 4 latches high on marker search done, only with bit interleave.
// - Bit 3 is live training frame delineation, no latch.
// - Bit 2 is live receiver trained and ready status.
// - Bit 1 slow PLL lock, bit 0 fast PLL lock, both latched low.
// - Fast counter counts bad code words, or pattern errors in test mode.
// - With the pattern check pin high, fast counter counts pseudo-random errors.
// - Each error counter clears to zero when the host reads it, or to one if an error comes in the read cycle.
// - Fast error counter resets to 0xFFFD.
// - Lane error counter shows the lane picked by the lane select field.
// - Lane counter counts bad code words, or lane pattern errors in test.
// - Lane error counter resets to 0xFFFD; status register resets to zero.
// - Self-clearing reset control bits return to zero the next cycle.
`default_nettype none
`include "csec_cfg.svh"

module csec_status_regs
  import csec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,
  // Management register port
  input wire logic regRdStb,
  input wire logic regWrStb,
  input wire logic [`CSEC_ADDR_W-1:0] regAddr,
  input wire logic [`CSEC_DATA_W-1:0] regWrData,
  output logic [`CSEC_DATA_W-1:0] regRdData,
  output logic regRdValid,
  // Configuration from the channel's configuration registers
  input wire logic [`CSEC_LANE_SEL_W-1:0] lane_select_field,
  input wire logic fastTestMode,
  input wire logic laneTestMode,
  input wire logic decoderEnable,
  input wire logic random_jitter_pattern,
  input wire logic rx_bitwise_interleave,
  // Pattern check enable pin, asynchronous
  input wire logic pattern_check_pin,
  // Live status from the datapath
  input wire logic fast_pattern_aligned,
  input wire logic training_failed_flag,
  input wire logic fast_signal_lost,
  input wire logic autozero_complete,
  input wire logic gain_loop_locked,
  input wire logic fast_sync_achieved,
  input wire logic fast_bad_codeword,
  input wire logic marker_search_done,
  input wire logic training_frame_found,
  input wire logic receiver_trained,
  input wire logic slow_pll_locked,
  input wire logic fast_pll_locked,
  // Error events, one cycle each
  input wire logic fastPatternErr,
  input wire logic fastPrbsErr,
  input wire logic [`CSEC_NUM_LANES-1:0] laneBadCodeword,
  input wire logic [`CSEC_NUM_LANES-1:0] lanePatternErr,
  // Self-clearing reset controls
  output logic [`CSEC_NUM_LANES-1:0] laneFifoReset,
  output logic restartTraining,
  output logic datapathReset
);

  csec_main_state_type cur_ff;
  csec_main_state_type nxt_cur;
  csec_cnt_if cntBus ();

  logic rdStatus;
  logic rdFast;
  logic rdLane;
  logic wrResetCtrl;
  logic badCodeQual;
  logic markerQual;
  logic fastErrEvent;
  csec_word_type statusWord;
  csec_word_type laneCount;

  //////////////////////////////////////////////////////////////////////
  // Register port decode: one strobe qualified by one register address
  function automatic logic hitAddr(
    input logic stb,
    input logic [`CSEC_ADDR_W-1:0] addr,
    input logic [`CSEC_ADDR_W-1:0] target
  );
    hitAddr = stb && (addr == target);
  endfunction

  // Lane select decode; selects past the last lane reach no counter
  function automatic logic laneInRange(
    input logic [`CSEC_LANE_SEL_W-1:0] sel
  );
    laneInRange = sel < `CSEC_LANE_SEL_W'(`CSEC_NUM_LANES);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Error counter bank: fast link plus four lanes
  csec_err_counters u_counters (
    .sys_clk(sys_clk),
    .srst(srst),
    .clkEn(clkEn),
    .cnt(cntBus.bank)
  );

  //////////////////////////////////////////////////////////////////////
  // Address decode of the management port
  assign rdStatus = hitAddr(regRdStb, regAddr, `CSEC_ADDR_STATUS);
  assign rdFast = hitAddr(regRdStb, regAddr, `CSEC_ADDR_FAST_ERR);
  assign rdLane = hitAddr(regRdStb, regAddr, `CSEC_ADDR_LANE_ERR);
  assign wrResetCtrl = hitAddr(regWrStb, regAddr, `CSEC_ADDR_RESET_CTRL);

  //////////////////////////////////////////////////////////////////////
  // Qualified latch events
  // Bad code words mean nothing unless the decoder or pattern check runs
  assign badCodeQual = fast_bad_codeword && (decoderEnable || random_jitter_pattern);
  // Marker search only applies to bit interleaved receive
  assign markerQual = marker_search_done && rx_bitwise_interleave;

  //////////////////////////////////////////////////////////////////////
  // Fast counter source: pin beats test mode beats functional mode
  always_comb
  begin
    if (cur_ff.patPinSync)
    begin
      fastErrEvent = fastPrbsErr;
    end
    else if (fastTestMode)
    begin
      fastErrEvent = fastPatternErr;
    end
    else
    begin
      fastErrEvent = fast_bad_codeword;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Counter increments and clear-on-read strobes
  always_comb
  begin
    cntBus.incr = '0;
    cntBus.clr = '0;
    cntBus.incr[`CSEC_FAST_IDX] = fastErrEvent;
    cntBus.clr[`CSEC_FAST_IDX] = rdFast;
    for (int i = 0; i < `CSEC_NUM_LANES; i++)
    begin
      // Every lane counts all the time; the select picks the view and the lane cleared on read
      cntBus.incr[`CSEC_LANE_BASE + i] = laneTestMode ? lanePatternErr[i] : laneBadCodeword[i];
    end
    // Only the selected lane clears; an out of range select clears nothing
    if (laneInRange(lane_select_field))
    begin
      cntBus.clr[`CSEC_LANE_BASE + lane_select_field] = rdLane;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Selected lane counter; an out of range select reads zero
  always_comb
  begin
    laneCount = `CSEC_ZERO16;
    if (laneInRange(lane_select_field))
    begin
      for (int i = 0; i < `CSEC_NUM_LANES; i++)
      begin
        if (lane_select_field == `CSEC_LANE_SEL_W'(i))
        begin
          laneCount = cntBus.count[`CSEC_LANE_BASE + i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status word as the host sees it; reserved bits read zero
  always_comb
  begin
    statusWord = `CSEC_STATUS_RESET;
    // Live bits are taken at the read edge and never latched
    statusWord[`CSEC_BIT_PAT_ALIGNED] = fast_pattern_aligned;
    statusWord[`CSEC_BIT_TRAIN_FAIL] = cur_ff.trainFailLatch;
    statusWord[`CSEC_BIT_SIG_LOST] = cur_ff.sigLostLatch;
    statusWord[`CSEC_BIT_AUTOZERO] = cur_ff.autozeroLatch;
    statusWord[`CSEC_BIT_GAIN_LOCK] = cur_ff.gainLockLatch;
    statusWord[`CSEC_BIT_SYNC] = cur_ff.syncLatch;
    statusWord[`CSEC_BIT_BAD_CODE] = cur_ff.badCodeLatch;
    statusWord[`CSEC_BIT_MARKER_DONE] = cur_ff.markerDoneLatch;
    statusWord[`CSEC_BIT_FRAME_FOUND] = training_frame_found;
    statusWord[`CSEC_BIT_RX_TRAINED] = receiver_trained;
    statusWord[`CSEC_BIT_SLOW_PLL] = cur_ff.slowPllLatch;
    statusWord[`CSEC_BIT_FAST_PLL] = cur_ff.fastPllLatch;
  end

  //////////////////////////////////////////////////////////////////////
  // Next state of the register block
  always_comb
  begin
    nxt_cur = cur_ff;

    // Two stage synchroniser for the pattern check pin
    // Only the second stage is read; the first may be metastable
    nxt_cur.patPinMeta = pattern_check_pin;
    nxt_cur.patPinSync = cur_ff.patPinMeta;

    // Latched-high bits: a read restarts them from the current event,
    // so an event in the read cycle is kept for the next read
    if (rdStatus)
    begin
      nxt_cur.trainFailLatch = training_failed_flag;
      nxt_cur.sigLostLatch = fast_signal_lost;
      nxt_cur.badCodeLatch = badCodeQual;
      nxt_cur.markerDoneLatch = markerQual;
    end
    else
    begin
      nxt_cur.trainFailLatch = cur_ff.trainFailLatch | training_failed_flag;
      nxt_cur.sigLostLatch = cur_ff.sigLostLatch | fast_signal_lost;
      nxt_cur.badCodeLatch = cur_ff.badCodeLatch | badCodeQual;
      nxt_cur.markerDoneLatch = cur_ff.markerDoneLatch | markerQual;
    end

    // Latched-low bits: a drop sticks until read, then live again
    if (rdStatus)
    begin
      nxt_cur.autozeroLatch = autozero_complete;
      nxt_cur.gainLockLatch = gain_loop_locked;
      nxt_cur.syncLatch = fast_sync_achieved;
      nxt_cur.slowPllLatch = slow_pll_locked;
      nxt_cur.fastPllLatch = fast_pll_locked;
    end
    else
    begin
      nxt_cur.autozeroLatch = cur_ff.autozeroLatch & autozero_complete;
      nxt_cur.gainLockLatch = cur_ff.gainLockLatch & gain_loop_locked;
      nxt_cur.syncLatch = cur_ff.syncLatch & fast_sync_achieved;
      nxt_cur.slowPllLatch = cur_ff.slowPllLatch & slow_pll_locked;
      nxt_cur.fastPllLatch = cur_ff.fastPllLatch & fast_pll_locked;
    end

    // Read answer one cycle after the strobe; unmapped reads give zero
    // Every strobe answers, so the host never waits on an unmapped hole
    nxt_cur.rdValid = regRdStb;
    if (rdStatus)
    begin
      nxt_cur.rdData = statusWord;
    end
    else if (rdFast)
    begin
      nxt_cur.rdData = cntBus.count[`CSEC_FAST_IDX];
    end
    else if (rdLane)
    begin
      nxt_cur.rdData = laneCount;
    end
    else if (regRdStb)
    begin
      nxt_cur.rdData = `CSEC_ZERO16;
    end

    // Reset controls last exactly one cycle after the write
    // Only the self-clearing fields live here; other write bits are dropped
    nxt_cur.laneFifoReset = '0;
    nxt_cur.restartTraining = 1'b0;
    nxt_cur.datapathReset = 1'b0;
    if (wrResetCtrl)
    begin
      nxt_cur.laneFifoReset = regWrData[`CSEC_RC_LANE_FIFO_HI:`CSEC_RC_LANE_FIFO_LO];
      nxt_cur.restartTraining = regWrData[`CSEC_RC_RESTART_TRAIN];
      nxt_cur.datapathReset = regWrData[`CSEC_RC_DATAPATH];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register; the clock enable freezes everything
  // Reset does not wait for the enable, so a frozen block still clears
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cur_ff <= '0;
    end
    else if (clkEn)
    begin
      cur_ff <= nxt_cur;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  // No decode glitch can reach a pin this way
  assign regRdData = cur_ff.rdData;
  assign regRdValid = cur_ff.rdValid;
  assign laneFifoReset = cur_ff.laneFifoReset;
  assign restartTraining = cur_ff.restartTraining;
  assign datapathReset = cur_ff.datapathReset;

endmodule : csec_status_regs
`default_nettype wire

//--- include/csec_cfg.svh
// Constants for the channel status and error counter register set
`ifndef CSEC_CFG_SVH
`define CSEC_CFG_SVH

// Register offsets on the management port
`define CSEC_ADDR_W 5
`define CSEC_ADDR_RESET_CTRL 5'h0E
`define CSEC_ADDR_STATUS 5'h0F
`define CSEC_ADDR_FAST_ERR 5'h10
`define CSEC_ADDR_LANE_ERR 5'h11

// Data width and reset values
`define CSEC_DATA_W 16
`define CSEC_STATUS_RESET 16'h0000
`define CSEC_ERR_RESET 16'hFFFD
`define CSEC_ERR_CLEARED 16'h0000
`define CSEC_ERR_MAX 16'hFFFF
`define CSEC_ZERO16 16'h0000

// Status register bit positions
`define CSEC_BIT_PAT_ALIGNED 15
`define CSEC_BIT_TRAIN_FAIL 14
`define CSEC_BIT_SIG_LOST 13
`define CSEC_BIT_AUTOZERO 12
`define CSEC_BIT_GAIN_LOCK 11
`define CSEC_BIT_SYNC 10
`define CSEC_BIT_BAD_CODE 8
`define CSEC_BIT_MARKER_DONE 4
`define CSEC_BIT_FRAME_FOUND 3
`define CSEC_BIT_RX_TRAINED 2
`define CSEC_BIT_SLOW_PLL 1
`define CSEC_BIT_FAST_PLL 0

// Reset control register fields (self clearing)
`define CSEC_RC_LANE_FIFO_HI 11
`define CSEC_RC_LANE_FIFO_LO 8
`define CSEC_RC_RESTART_TRAIN 4
`define CSEC_RC_DATAPATH 3

// Counter arrangement: index 0 is the fast link, 1..4 are lanes 0..3
`define CSEC_NUM_LANES 4
`define CSEC_NUM_CNT 5
`define CSEC_LANE_SEL_W 3
`define CSEC_FAST_IDX 0
`define CSEC_LANE_BASE 1

`endif

//--- include/csec_cnt_if.sv
// Connection between the register block and its error counter bank
`default_nettype none
`include "csec_cfg.svh"

interface csec_cnt_if;
  logic [`CSEC_NUM_CNT-1:0] incr;
  logic [`CSEC_NUM_CNT-1:0] clr;
  logic [`CSEC_NUM_CNT-1:0][`CSEC_DATA_W-1:0] count;

  modport regs (output incr, output clr, input count);
  modport bank (input incr, input clr, output count);
endinterface : csec_cnt_if

`default_nettype wire

//--- include/csec_pkg.sv
// Types for the channel status and error counter register set
`default_nettype none
`include "csec_cfg.svh"

package csec_pkg;

  typedef logic [`CSEC_DATA_W-1:0] csec_word_type;

  // State of the main register block
  typedef struct packed {
    logic patPinMeta;
    logic patPinSync;
    logic trainFailLatch;
    logic sigLostLatch;
    logic badCodeLatch;
    logic markerDoneLatch;
    logic autozeroLatch;
    logic gainLockLatch;
    logic syncLatch;
    logic slowPllLatch;
    logic fastPllLatch;
    csec_word_type rdData;
    logic rdValid;
    logic [`CSEC_NUM_LANES-1:0] laneFifoReset;
    logic restartTraining;
    logic datapathReset;
  } csec_main_state_type;

  // State of the counter bank
  typedef struct packed {
    csec_word_type [`CSEC_NUM_CNT-1:0] count;
  } csec_cnt_state_type;

endpackage : csec_pkg

`default_nettype wire
